// >>> hdl/uart_shadow_pkg.sv
// constants shared by the shadow data port and its byte queues
package uart_shadow_pkg;
  // data path and queue geometry
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int CNT_W      = 5;

  // register byte addresses
  localparam logic [31:0] ADDR_SHADOW_FIRST = 32'h5000_1130;
  localparam logic [31:0] ADDR_SHADOW_LAST  = 32'h5000_116C;
  localparam logic [31:0] ADDR_SHADOW_11    = 32'h5000_115C;
  localparam logic [31:0] ADDR_SHADOW_12    = 32'h5000_1160;
  localparam logic [31:0] ADDR_CTRL         = 32'h5000_1180;
  localparam logic [31:0] ADDR_LINE_STATUS  = 32'h5000_1184;
  localparam logic [31:0] ADDR_INT_STATUS   = 32'h5000_1188;
  localparam logic [31:0] ADDR_INT_MASK     = 32'h5000_118C;

  // control fields
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 1;

  // line status fields
  localparam int LSR_DATA_READY_BIT    = 0;
  localparam int LSR_OVERRUN_BIT       = 1;
  localparam int LSR_HOLDING_EMPTY_BIT = 5;

  // interrupt status and mask fields
  localparam int INT_OVERRUN_BIT = 0;
  localparam int INT_RX_BIT      = 1;
  localparam int INT_TX_LOST_BIT = 2;

  // reset values
  localparam logic [7:0]  RESET_DATA = 8'h00;
  localparam logic [1:0]  RESET_CTRL = 2'h0;
  localparam logic [2:0]  RESET_INT  = 3'h0;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;
endpackage

// >>> hdl/uart_byte_fifo.sv
// byte queue in flip-flops, sixteen entries, used for receive and transmit
`timescale 1ns/10ps
module uart_byte_fifo (
  // clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // control
  input  wire logic                                flush,
  // write side
  input  wire logic                                push,
  input  wire logic [uart_shadow_pkg::DATA_W-1:0]  push_data,
  // read side
  input  wire logic                                pop,
  output logic      [uart_shadow_pkg::DATA_W-1:0]  head_data,
  // state
  output logic                                     full,
  output logic                                     empty
);
  logic [uart_shadow_pkg::DATA_W-1:0] mem [uart_shadow_pkg::FIFO_DEPTH];
  logic [uart_shadow_pkg::DATA_W-1:0] next_mem [uart_shadow_pkg::FIFO_DEPTH];
  logic [uart_shadow_pkg::PTR_W-1:0]  wr_ptr;
  logic [uart_shadow_pkg::PTR_W-1:0]  rd_ptr;
  logic [uart_shadow_pkg::CNT_W-1:0]  count;
  logic [uart_shadow_pkg::PTR_W-1:0]  next_wr_ptr;
  logic [uart_shadow_pkg::PTR_W-1:0]  next_rd_ptr;
  logic [uart_shadow_pkg::CNT_W-1:0]  next_count;
  logic                               do_push;
  logic                               do_pop;

  assign full      = (count == uart_shadow_pkg::CNT_W'(uart_shadow_pkg::FIFO_DEPTH));
  assign empty     = (count == '0);
  assign head_data = mem[rd_ptr];
  // a push into a full queue is dropped here, the caller reports it
  assign do_push   = push & ~full;
  assign do_pop    = pop & ~empty;

  // widen a one-bit step to the count width so the sum keeps its size
  function automatic logic [uart_shadow_pkg::CNT_W-1:0] count_step(input logic b);
    count_step = {{(uart_shadow_pkg::CNT_W-1){1'b0}}, b};
  endfunction

  // pointer and storage update; flush wins over traffic
  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (do_push) begin
        next_mem[wr_ptr] = push_data;
        next_wr_ptr      = wr_ptr + 1'b1;
      end
      if (do_pop) begin
        next_rd_ptr = rd_ptr + 1'b1;
      end
      next_count = count + count_step(do_push) - count_step(do_pop);
    end
  end

  // storage register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < uart_shadow_pkg::FIFO_DEPTH; i++) begin
        mem[i] <= uart_shadow_pkg::RESET_DATA;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule

// >>> hdl/uart_shadow_data_port.sv
// shadow receive/transmit data port of a uart, with apb slave and interrupt
//
// Operation
// - all sixteen shadow words alias one receive buffer for burst access
// - read bits 7:0 give the byte from serial or infrared input
// - without fifos an unread byte is overwritten and overrun flagged
// - with fifos a read returns the receive fifo head
// - full receive fifo keeps entries, drops new byte, flags overrun
// - a write supplies the byte for serial or infrared transmission
// - without fifos one write clears holding empty
// - without fifos further writes replace the pending transmit byte
// - with fifos up to sixteen writes are accepted before full
// - writes into a full transmit fifo are discarded
// - data resets to zero, upper bits read zero
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module uart_shadow_data_port (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // received bytes from the serial and infrared deserialisers
  input  wire logic        rx_strobe,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_ir_strobe,
  input  wire logic [7:0]  rx_ir_byte,
  // transmit byte stream to the serialiser
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_byte,
  output logic             tx_ir_mode,
  // interrupt
  output logic             irq
);
  // an address is a shadow alias when it is one of the sixteen aligned words
  function automatic logic is_shadow(input logic [31:0] a);
    is_shadow = (a >= uart_shadow_pkg::ADDR_SHADOW_FIRST) &&
                (a <= uart_shadow_pkg::ADDR_SHADOW_LAST) && (a[1:0] == 2'b00);
  endfunction

  logic [1:0]  ctrl;
  logic [2:0]  int_status;
  logic [2:0]  int_mask;
  logic        overrun;
  logic [7:0]  rx_hold;
  logic        rx_hold_valid;
  logic [7:0]  tx_hold;
  logic        tx_hold_full;
  logic        rd_pop_ok;
  logic        err_q;
  logic [1:0]  next_ctrl;
  logic [2:0]  next_int_status;
  logic [2:0]  next_int_mask;
  logic        next_overrun;
  logic [7:0]  next_rx_hold;
  logic        next_rx_hold_valid;
  logic [7:0]  next_tx_hold;
  logic        next_tx_hold_full;
  logic        next_rd_pop_ok;
  logic        next_err_q;
  logic [31:0] next_prdata;
  logic        setup;
  logic        access;
  logic        shadow_hit;
  logic        tx_write;
  logic        fifo_en;
  logic        flush;
  logic        rx_in_valid;
  logic [7:0]  rx_in_data;
  logic        rx_pop_bus;
  logic        rx_full;
  logic        rx_empty;
  logic [7:0]  rx_head;
  logic        tx_full;
  logic        tx_empty;
  logic [7:0]  tx_head;
  logic        tx_take;
  logic        data_ready;
  logic        holding_empty;
  logic        ev_overrun;
  logic        ev_tx_lost;
  logic [7:0]  rx_read_byte;
  logic [31:0] line_status_reg;
  logic [2:0]  events;

  // bus phases and decode; zero wait states
  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  assign shadow_hit = is_shadow(paddr);
  assign tx_write   = access & pwrite & shadow_hit;
  assign pready     = 1'b1;
  assign pslverr    = access & err_q;

  // mode bits; changing the fifo mode flushes both directions
  assign fifo_en    = ctrl[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
  assign tx_ir_mode = ctrl[uart_shadow_pkg::CTRL_IR_MODE_BIT];
  assign flush      = access & pwrite & (paddr == uart_shadow_pkg::ADDR_CTRL) &
                      (pwdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT] != fifo_en);

  // input select between uart and infrared receivers
  assign rx_in_valid = tx_ir_mode ? rx_ir_strobe : rx_strobe;
  assign rx_in_data  = tx_ir_mode ? rx_ir_byte : rx_byte;

  // pop only if data was ready at setup, so a byte landing mid-read is kept
  assign rx_pop_bus  = access & ~pwrite & shadow_hit & rd_pop_ok;

  // status seen by software
  assign data_ready    = fifo_en ? ~rx_empty : rx_hold_valid;
  assign holding_empty = fifo_en ? tx_empty : ~tx_hold_full;
  assign rx_read_byte  = fifo_en ? rx_head : rx_hold;

  // overrun: byte lost to a full fifo, or unread holding byte overwritten
  assign ev_overrun = rx_in_valid & ~flush &
                      (fifo_en ? rx_full : (rx_hold_valid & ~rx_pop_bus));
  assign ev_tx_lost = tx_write & fifo_en & tx_full & ~flush;

  // transmit stream to the serialiser
  assign tx_valid = fifo_en ? ~tx_empty : tx_hold_full;
  assign tx_byte  = fifo_en ? tx_head : tx_hold;
  assign tx_take  = tx_valid & tx_ready;

  // line status view
  always_comb begin
    line_status_reg = uart_shadow_pkg::READ_ZERO;
    line_status_reg[uart_shadow_pkg::LSR_DATA_READY_BIT]    = data_ready;
    line_status_reg[uart_shadow_pkg::LSR_OVERRUN_BIT]       = overrun;
    line_status_reg[uart_shadow_pkg::LSR_HOLDING_EMPTY_BIT] = holding_empty;
  end

  // interrupt events, same layout as status and mask
  always_comb begin
    events = '0;
    events[uart_shadow_pkg::INT_OVERRUN_BIT] = ev_overrun;
    events[uart_shadow_pkg::INT_RX_BIT]      = rx_in_valid & ~flush;
    events[uart_shadow_pkg::INT_TX_LOST_BIT] = ev_tx_lost;
  end

  assign irq = |(int_status & int_mask);

  // receive fifo; a push while full is dropped, stored entries stay
  uart_byte_fifo u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (flush),
    .push      (fifo_en & rx_in_valid),
    .push_data (rx_in_data),
    .pop       (fifo_en & rx_pop_bus),
    .head_data (rx_head),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  // transmit fifo; sixteen writes fill it, more are discarded
  uart_byte_fifo u_tx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (flush),
    .push      (fifo_en & tx_write),
    .push_data (pwdata[7:0]),
    .pop       (fifo_en & tx_take),
    .head_data (tx_head),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // next register state: bus side effects, holding registers, flags
  always_comb begin
    next_ctrl          = ctrl;
    next_int_mask      = int_mask;
    next_int_status    = int_status;
    next_overrun       = overrun;
    next_rx_hold       = rx_hold;
    next_rx_hold_valid = rx_hold_valid;
    next_tx_hold       = tx_hold;
    next_tx_hold_full  = tx_hold_full;
    next_rd_pop_ok     = rd_pop_ok;
    next_err_q         = err_q;
    next_prdata        = prdata;
    // setup phase: latch read data and decode error ahead of access
    if (setup) begin
      next_err_q     = 1'b0;
      next_rd_pop_ok = data_ready;
      next_prdata    = uart_shadow_pkg::READ_ZERO;
      if (shadow_hit) begin
        next_prdata[7:0] = pwrite ? uart_shadow_pkg::RESET_DATA : rx_read_byte;
      end else if (paddr == uart_shadow_pkg::ADDR_CTRL) begin
        next_prdata[1:0] = ctrl;
      end else if (paddr == uart_shadow_pkg::ADDR_LINE_STATUS) begin
        next_prdata = line_status_reg;
      end else if (paddr == uart_shadow_pkg::ADDR_INT_STATUS) begin
        next_prdata[2:0] = int_status;
      end else if (paddr == uart_shadow_pkg::ADDR_INT_MASK) begin
        next_prdata[2:0] = int_mask;
      end else begin
        next_err_q = 1'b1;
      end
    end
    // register writes and read side effects; events are ored in after
    if (access && !err_q) begin
      if (pwrite && paddr == uart_shadow_pkg::ADDR_CTRL) begin
        next_ctrl = pwdata[1:0];
      end
      if (pwrite && paddr == uart_shadow_pkg::ADDR_INT_MASK) begin
        next_int_mask = pwdata[2:0];
      end
      if (pwrite && paddr == uart_shadow_pkg::ADDR_INT_STATUS) begin
        next_int_status = int_status & ~pwdata[2:0];
      end
      if (!pwrite && paddr == uart_shadow_pkg::ADDR_LINE_STATUS) begin
        next_overrun = 1'b0;
      end
    end
    // set wins over clear for every sticky flag
    next_int_status = next_int_status | events;
    if (ev_overrun) begin
      next_overrun = 1'b1;
    end
    // non-fifo receive holding byte
    if (rx_pop_bus && !fifo_en) begin
      next_rx_hold_valid = 1'b0;
    end
    if (rx_in_valid && !fifo_en) begin
      next_rx_hold       = rx_in_data;
      next_rx_hold_valid = 1'b1;
    end
    // non-fifo transmit holding byte; a write after the take wins
    if (tx_take && !fifo_en) begin
      next_tx_hold_full = 1'b0;
    end
    if (tx_write && !fifo_en) begin
      next_tx_hold      = pwdata[7:0];
      next_tx_hold_full = 1'b1;
    end
    if (flush) begin
      next_rx_hold_valid = 1'b0;
      next_tx_hold_full  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl          <= uart_shadow_pkg::RESET_CTRL;
      int_mask      <= uart_shadow_pkg::RESET_INT;
      int_status    <= uart_shadow_pkg::RESET_INT;
      overrun       <= 1'b0;
      rx_hold       <= uart_shadow_pkg::RESET_DATA;
      rx_hold_valid <= 1'b0;
      tx_hold       <= uart_shadow_pkg::RESET_DATA;
      tx_hold_full  <= 1'b0;
      rd_pop_ok     <= 1'b0;
      err_q         <= 1'b0;
      prdata        <= uart_shadow_pkg::READ_ZERO;
    end else begin
      ctrl          <= next_ctrl;
      int_mask      <= next_int_mask;
      int_status    <= next_int_status;
      overrun       <= next_overrun;
      rx_hold       <= next_rx_hold;
      rx_hold_valid <= next_rx_hold_valid;
      tx_hold       <= next_tx_hold;
      tx_hold_full  <= next_tx_hold_full;
      rd_pop_ok     <= next_rd_pop_ok;
      err_q         <= next_err_q;
      prdata        <= next_prdata;
    end
  end

  // checks on the data port behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ALIAS_READ: assert property (
    setup && !pwrite && shadow_hit |=> prdata[7:0] == $past(rx_read_byte))
    else $error("shadow read did not return the receive byte");
  AST_UPPER_ZERO: assert property (
    setup && shadow_hit |=> prdata[31:8] == 24'h0000_00)
    else $error("reserved shadow bits not zero");
  AST_IR_SELECT: assert property (
    !fifo_en && tx_ir_mode && rx_ir_strobe && !flush |=> rx_hold == $past(rx_ir_byte))
    else $error("infrared byte not captured");
  AST_OVERWRITE: assert property (
    !fifo_en && rx_hold_valid && rx_in_valid && !rx_pop_bus && !flush
    |=> overrun && rx_hold == $past(rx_in_data) && data_ready)
    else $error("overrun without fifo not handled");
  AST_FIFO_HEAD: assert property (
    fifo_en && setup && !pwrite && shadow_hit
    |=> prdata[7:0] == $past(rx_head))
    else $error("fifo read did not return the head entry");
  AST_FIFO_DROP: assert property (
    fifo_en && rx_full && rx_in_valid && !rx_pop_bus && !flush
    |=> rx_full && overrun && int_status[uart_shadow_pkg::INT_OVERRUN_BIT])
    else $error("full receive fifo overrun not flagged");
  AST_HOLDING_EMPTY_FLAG_CLEAR: assert property (
    !fifo_en && holding_empty && tx_write && !flush |=> !holding_empty ##0 tx_valid)
    else $error("holding empty not cleared by write");
  AST_TX_REPLACE: assert property (
    !fifo_en && tx_write && !flush |=> tx_hold == $past(pwdata[7:0]))
    else $error("pending transmit byte not replaced");
  AST_TX_ACCEPT: assert property (
    fifo_en && !tx_full && tx_write && !flush |=> !tx_empty)
    else $error("transmit fifo refused a write with room");
  AST_TX_DISCARD: assert property (
    fifo_en && tx_full && tx_write && !tx_take && !flush
    |=> tx_full && int_status[uart_shadow_pkg::INT_TX_LOST_BIT] && tx_head == $past(tx_head))
    else $error("write into full transmit fifo changed it");
  AST_DR_CLEAR: assert property (
    !fifo_en && rx_pop_bus && !rx_in_valid |=> !data_ready)
    else $error("data ready not cleared by read");

  COV_OVERRUN: cover property (ev_overrun ##1 irq);
  COV_TX_FULL: cover property (fifo_en && tx_full && tx_write);
  COV_BURST:   cover property (rx_pop_bus ##2 rx_pop_bus);
endmodule

// >>> testbench/uart_far_end.sv
// far-side serial model: feeds received bytes and takes transmit bytes
`timescale 1ns/10ps
module uart_far_end (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench control
  input  wire logic       stall,
  // receive side toward the port
  output logic            rx_strobe,
  output logic      [7:0] rx_byte,
  output logic            rx_ir_strobe,
  output logic      [7:0] rx_ir_byte,
  // transmit side from the port
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  logic [7:0]  got [$];
  logic [15:0] lfsr;

  // quiet lines at time zero
  initial begin
    rx_strobe    = 1'b0;
    rx_ir_strobe = 1'b0;
    rx_byte      = 8'h00;
    rx_ir_byte   = 8'h00;
  end

  // one strobe per byte on the chosen input; idle lines show the inverse
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge pclk);
    if (ir) begin
      rx_ir_strobe <= 1'b1;
      rx_ir_byte   <= b;
    end else begin
      rx_strobe <= 1'b1;
      rx_byte   <= b;
    end
    @(posedge pclk);
    rx_strobe    <= 1'b0;
    rx_ir_strobe <= 1'b0;
    rx_byte      <= ~b;
    rx_ir_byte   <= ~b;
  endtask

  // ready comes and goes so the port meets both quick and slow takers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr     <= 16'h0001;
      tx_ready <= 1'b0;
    end else begin
      lfsr     <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      tx_ready <= !stall && lfsr[0];
    end
  end

  // a byte is taken at an edge with valid and ready both high
  always @(posedge pclk) begin
    if (presetn && tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_byte);
    end
  end
endmodule

// >>> testbench/tb_uart_shadow_data_port.sv
// self-checking bench for the shadow data port
`timescale 1ns/10ps
module tb_uart_shadow_data_port;
  localparam logic [31:0] A_LINE = uart_shadow_pkg::ADDR_LINE_STATUS;
  localparam logic [31:0] A_CTRL = uart_shadow_pkg::ADDR_CTRL;
  localparam logic [31:0] A_IST  = uart_shadow_pkg::ADDR_INT_STATUS;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, stall, err;
  logic        tx_valid, tx_ready, tx_ir_mode, irq, rx_strobe, rx_ir_strobe;
  logic [31:0] paddr, pwdata, prdata, rd, seed, r, q;
  logic [7:0]  tx_byte, rx_byte, rx_ir_byte;
  logic [7:0]  exp_q [$];
  int          err_total, n_tests, base;

  always #10 pclk = ~pclk;

  uart_shadow_data_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_strobe(rx_strobe), .rx_byte(rx_byte), .rx_ir_strobe(rx_ir_strobe),
    .rx_ir_byte(rx_ir_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .tx_ir_mode(tx_ir_mode), .irq(irq));

  uart_far_end u_far (.pclk(pclk), .presetn(presetn), .stall(stall), .rx_strobe(rx_strobe),
    .rx_byte(rx_byte), .rx_ir_strobe(rx_ir_strobe), .rx_ir_byte(rx_ir_byte),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

  // xorshift source, fixed start for repeatable runs
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // any of the sixteen aliased words
  function automatic logic [31:0] alias_addr();
    logic [31:0] t;
    t = rnd();
    return uart_shadow_pkg::ADDR_SHADOW_FIRST + {26'h000_0000, t[3:0], 2'b00};
  endfunction

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // one apb transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (pready !== 1'b1 && k >= 50) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, m, e);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, e, rd & m);
  endtask

  // polls line status until the holding flag returns, bounded
  task automatic wait_he;
    int k;
    k = 0;
    do begin
      apb(1'b0, A_LINE, 32'h0000_0000);
      k++;
    end while (rd[uart_shadow_pkg::LSR_HOLDING_EMPTY_BIT] !== 1'b1 && k < 100);
    chk("holding empty", 32'h0000_0020, rd & 32'h0000_0020);
    if (k >= 100) begin
      end_sim();
    end
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    stall = 1'b1;
    seed = 32'h0000_0010;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped access, unmask only the lost-write event
    chk("irq reset", 32'h0000_0000, {31'h0, irq});
    rd_chk("word 11", uart_shadow_pkg::ADDR_SHADOW_11, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk("word 12", uart_shadow_pkg::ADDR_SHADOW_12, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk("status reset", A_LINE, 32'h0000_0023, 32'h0000_0020);
    apb(1'b0, 32'h5000_1200, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, err});
    apb(1'b1, uart_shadow_pkg::ADDR_INT_MASK, 32'h0000_0004);
    // single byte, then an unread byte overwritten
    r = rnd();
    u_far.send(1'b0, r[7:0]);
    rd_chk("ready set", A_LINE, 32'h0000_0001, 32'h0000_0001);
    rd_chk("rx byte", alias_addr(), 32'hFFFF_FFFF, {24'h0, r[7:0]});
    rd_chk("ready clear", A_LINE, 32'h0000_0001, 32'h0000_0000);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    q = r ^ 32'h0000_00A5;
    u_far.send(1'b0, r[7:0]);
    u_far.send(1'b0, q[7:0]);
    rd_chk("overrun", A_LINE, 32'h0000_0003, 32'h0000_0003);
    rd_chk("rx newest", alias_addr(), 32'hFFFF_FFFF, {24'h0, q[7:0]});
    // infrared mode takes only the infrared input
    apb(1'b1, A_CTRL, 32'h0000_0002);
    chk("ir mode out", 32'h0000_0001, {31'h0, tx_ir_mode});
    u_far.send(1'b0, r[7:0]);
    rd_chk("uart ignored", A_LINE, 32'h0000_0001, 32'h0000_0000);
    u_far.send(1'b1, q[7:0]);
    rd_chk("ir byte", alias_addr(), 32'hFFFF_FFFF, {24'h0, q[7:0]});
    apb(1'b1, A_CTRL, 32'h0000_0000);
    // two writes while the taker stalls: the later one replaces the first
    apb(1'b1, alias_addr(), r);
    rd_chk("holding full", A_LINE, 32'h0000_0020, 32'h0000_0000);
    chk("tx valid", 32'h0000_0001, {31'h0, tx_valid});
    chk("tx pending", {24'h0, r[7:0]}, {24'h0, tx_byte});
    apb(1'b1, alias_addr(), q);
    chk("tx replaced", {24'h0, q[7:0]}, {24'h0, tx_byte});
    base = u_far.got.size();
    stall <= 1'b0;
    wait_he();
    stall <= 1'b1;
    chk("tx count", 32'(base + 1), 32'(u_far.got.size()));
    chk("tx byte", {24'h0, q[7:0]}, {24'h0, u_far.got[base]});
    // fifo receive: seventeen bytes into sixteen places
    apb(1'b1, A_CTRL, 32'h0000_0001);
    for (int i = 0; i < 17; i++) begin
      r = rnd();
      exp_q.push_back(r[7:0]);
      u_far.send(1'b0, r[7:0]);
    end
    rd_chk("fifo overrun", A_LINE, 32'h0000_0003, 32'h0000_0003);
    for (int i = 0; i < 16; i++) begin
      rd_chk("fifo head", alias_addr(), 32'hFFFF_FFFF, {24'h0, exp_q[i]});
    end
    rd_chk("fifo drained", A_LINE, 32'h0000_0001, 32'h0000_0000);
    // fifo transmit: seventeen writes against a stalled taker
    apb(1'b1, A_IST, 32'h0000_0007);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    wait_he();
    exp_q.delete();
    base = u_far.got.size();
    for (int i = 0; i < 17; i++) begin
      r = rnd();
      exp_q.push_back(r[7:0]);
      apb(1'b1, alias_addr(), r);
    end
    chk("irq lost write", 32'h0000_0001, {31'h0, irq});
    rd_chk("lost status", A_IST, 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, A_IST, 32'h0000_0004);
    chk("irq w1c", 32'h0000_0000, {31'h0, irq});
    stall <= 1'b0;
    wait_he();
    chk("fifo tx count", 32'(base + 16), 32'(u_far.got.size()));
    for (int i = 0; i < 16; i++) begin
      chk("fifo tx byte", {24'h0, exp_q[i]}, {24'h0, u_far.got[base + i]});
    end
    end_sim();
  end
endmodule
